// [design/iwa_decoder.sv]
// internal word allocation decoder with an AXI4-Lite register slave
//
// Function
// - special module: ten words from 100 by unit
// - five slave racks, ten words from 050
// - wide slave rack takes next unit's block too
// - optical unit or terminal at 200 plus unit
// - remote master and link modules get no words
// - fuse flag in bit 08, not work bit
// - alarm in bits 08-11, 08-15 barred
// - main rack interrupt input uses low eight bits
// - expansion rack interrupt input acts ordinary
// - 32-point dense module: two words from 30+2n
// - 64-point dense: four words, number nine invalid
// - dense modules not counted as special modules
// - dense words map to connector rows in order
// - special flag area words 236 to 511
// - status flags stay clear until condition
// - restart bit set then cleared restarts link
// - wide slave rack words by installed module order
// - rack slots take one word, ten per rack
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`default_nettype none

module iwa_decoder #(
   parameter int unsigned SPEC_LIMIT  = 10,
   parameter int unsigned SLAVE_RACKS = 5,
   parameter int unsigned EXP_RACKS   = 2
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             link_restart,
   output logic             config_error
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == iwa_pkg::OFF_CTRL)   || (a == iwa_pkg::OFF_REQ)    ||
                  (a == iwa_pkg::OFF_RESULT) || (a == iwa_pkg::OFF_MASK)   ||
                  (a == iwa_pkg::OFF_STATUS) || (a == iwa_pkg::OFF_OCCUPY) ||
                  (a == iwa_pkg::OFF_QUERY)  || (a == iwa_pkg::OFF_BITADDR) ||
                  (a == iwa_pkg::OFF_ROWMAP);
   endfunction : is_mapped

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      merge = r;
   endfunction : merge

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0]  aw_addr;
   logic        aw_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        w_held;
   logic [31:0] ctrl;
   logic [31:0] req;
   logic [31:0] query;
   logic        decode_go;
   logic        committed;
   logic [8:0]  res_word;
   logic [3:0]  res_count;
   logic [15:0] res_flags;
   logic [15:0] res_barred;
   logic [7:0]  res_rows;
   logic        res_err;
   logic        res_valid;
   logic [19:0] occupy;
   logic [3:0]  spec_count;
   logic [15:0] bit_addr;
   logic        in_sfa;
   logic        wr_fire;
   logic        wr_ok;
   logic        clear_cmd;
   logic [31:0] ctrl_merged;

   logic [8:0]  next_word;
   logic [3:0]  next_count;
   logic [15:0] next_flags;
   logic [15:0] next_barred;
   logic [7:0]  next_rows;
   logic [19:0] next_span;
   logic        next_err;
   logic        next_special;

   logic [3:0]  kind;
   logic [4:0]  unit;
   logic [1:0]  rack;
   logic [4:0]  pos;
   logic        wide;

   assign kind = req[iwa_pkg::REQ_KIND_LSB +: 4];
   assign unit = req[iwa_pkg::REQ_UNIT_LSB +: 5];
   assign rack = req[iwa_pkg::REQ_RACK_LSB +: 2];
   assign pos  = req[iwa_pkg::REQ_POS_LSB +: 5];
   assign wide = req[iwa_pkg::REQ_WIDE_BIT];

   // write executes once address and data are both held
   assign wr_fire   = aw_held && w_held && !s_axi_bvalid;
   assign wr_ok     = is_mapped(aw_addr);
   assign clear_cmd = ctrl[iwa_pkg::CTRL_CLEAR_BIT];
   // control word as the pending write would leave it
   assign ctrl_merged = merge(ctrl, w_data, w_strb);

   // ------------------------------------------------------------
   // AXI4-Lite write channels
   // ------------------------------------------------------------
   // address and data taken in either order, response after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr       <= '0;
         aw_held       <= 1'b0;
         w_data        <= iwa_pkg::RST_WORD;
         w_strb        <= '0;
         w_held        <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= iwa_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr       <= s_axi_awaddr;
            aw_held       <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            w_held       <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? iwa_pkg::RESP_OKAY : iwa_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // writable registers
   // ------------------------------------------------------------
   // clear bit self-clears; a write to the request starts a decode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl      <= iwa_pkg::RST_WORD;
         req       <= iwa_pkg::RST_WORD;
         query     <= iwa_pkg::RST_WORD;
         decode_go <= 1'b0;
      end else begin
         decode_go <= 1'b0;
         if (clear_cmd) begin
            ctrl[iwa_pkg::CTRL_CLEAR_BIT] <= 1'b0;
         end
         if (wr_fire && (aw_addr == iwa_pkg::OFF_CTRL)) begin
            ctrl <= merge(ctrl, w_data, w_strb) & 32'h0000_0003;
         end
         if (wr_fire && (aw_addr == iwa_pkg::OFF_REQ)) begin
            req       <= merge(req, w_data, w_strb) & 32'h0001_FFFF;
            decode_go <= 1'b1;
         end
         if (wr_fire && (aw_addr == iwa_pkg::OFF_QUERY)) begin
            query <= merge(query, w_data, w_strb) & 32'h000F_01FF;
         end
      end
   end

   // ------------------------------------------------------------
   // allocation decode of the held request
   // ------------------------------------------------------------
   always_comb begin
      next_word    = '0;
      next_count   = '0;
      next_flags   = '0;
      next_barred  = '0;
      next_rows    = '0;
      next_span    = '0;
      next_err     = 1'b0;
      next_special = 1'b0;
      unique case (kind)
         iwa_pkg::K_ORDINARY, iwa_pkg::K_FUSE_OUT,
         iwa_pkg::K_ALARM_OUT, iwa_pkg::K_INTR_IN: begin
            // one word per slot, ten per rack
            next_err    = (32'(rack) > EXP_RACKS) || (pos > iwa_pkg::SLOT_LAST);
            next_word   = 9'(rack * iwa_pkg::RACK_STEP + 9'(pos));
            next_count  = 4'h1;
            next_barred = iwa_pkg::M_ALL;
            if (kind == iwa_pkg::K_FUSE_OUT) begin
               next_flags  = iwa_pkg::M_FUSE;
               next_barred = iwa_pkg::M_HIGH8 | iwa_pkg::M_LOW8;
            end
            if (kind == iwa_pkg::K_ALARM_OUT) begin
               next_flags = iwa_pkg::M_ALARM;
            end
            if ((kind == iwa_pkg::K_INTR_IN) && (rack == 2'h0)) begin
               next_barred = iwa_pkg::M_LOW8;
            end
         end
         iwa_pkg::K_SPECIAL: begin
            next_err     = (unit > iwa_pkg::SPEC_UNIT_LAST) ||
                           (32'(spec_count) >= SPEC_LIMIT);
            next_word    = 9'(iwa_pkg::SPEC_BASE + iwa_pkg::SPEC_STEP * 9'(unit));
            next_count   = iwa_pkg::SPEC_WORDS;
            next_barred  = iwa_pkg::M_ALL;
            next_special = 1'b1;
         end
         iwa_pkg::K_SLAVE: begin
            // words follow installed module order, not slots
            next_err    = (32'(unit) >= SLAVE_RACKS) ||
                          (wide && (32'(unit) == SLAVE_RACKS - 1)) ||
                          (pos > (wide ? iwa_pkg::WIDE_POS_LAST : iwa_pkg::SLOT_LAST));
            next_word   = 9'(iwa_pkg::SLAVE_BASE + iwa_pkg::RACK_STEP * 9'(unit)
                             + 9'(pos));
            next_count  = 4'h1;
            next_barred = iwa_pkg::M_ALL;
         end
         iwa_pkg::K_OPTICAL: begin
            next_word   = 9'(iwa_pkg::OPT_BASE + 9'(unit));
            next_count  = 4'h1;
            next_barred = iwa_pkg::M_ALL;
         end
         iwa_pkg::K_LINK: begin
            next_count = 4'h0;
         end
         iwa_pkg::K_HD32, iwa_pkg::K_SERIAL, iwa_pkg::K_HD64: begin
            next_word   = 9'(iwa_pkg::HD_BASE + 9'(unit) * 9'h002);
            next_barred = iwa_pkg::M_ALL;
            if (kind == iwa_pkg::K_HD64) begin
               next_count = 4'h4;
               next_rows  = iwa_pkg::ROWS_FOUR;
               next_span  = 20'(24'h00000F << (2 * unit));
               next_err   = unit > iwa_pkg::HD64_UNIT_LAST;
            end else begin
               next_count = 4'h2;
               next_rows  = iwa_pkg::ROWS_TWO;
               next_span  = 20'(24'h000003 << (2 * unit));
               next_err   = unit > iwa_pkg::HD_UNIT_LAST;
            end
            next_err = next_err || ((next_span & occupy) != 20'h00000);
         end
         default: begin
            next_err = 1'b1;
         end
      endcase
   end

   // ------------------------------------------------------------
   // decode results
   // ------------------------------------------------------------
   // latched one cycle after the request write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         res_word   <= '0;
         res_count  <= '0;
         res_flags  <= '0;
         res_barred <= '0;
         res_rows   <= '0;
         res_err    <= 1'b0;
         res_valid  <= 1'b0;
         committed  <= 1'b0;
      end else begin
         committed <= decode_go;
         if (decode_go) begin
            res_word   <= next_word;
            res_count  <= next_count;
            res_flags  <= next_flags;
            res_barred <= next_barred;
            res_rows   <= next_rows;
            res_err    <= next_err;
            res_valid  <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // occupancy, special count and sticky error
   // ------------------------------------------------------------
   // a new claim or error wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         occupy       <= '0;
         spec_count   <= '0;
         config_error <= 1'b0;
      end else begin
         if (clear_cmd) begin
            occupy       <= '0;
            spec_count   <= '0;
            config_error <= 1'b0;
         end
         if (decode_go && next_err) begin
            config_error <= 1'b1;
         end
         if (decode_go && !next_err) begin
            occupy <= (clear_cmd ? 20'h00000 : occupy) | next_span;
            if (next_special) begin
               spec_count <= (clear_cmd ? 4'h0 : spec_count) + 4'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // special flag area bit address and restart pulse
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bit_addr     <= '0;
         in_sfa       <= 1'b0;
         link_restart <= 1'b0;
      end else begin
         bit_addr <= 16'(16'(query[iwa_pkg::QRY_WORD_LSB +: 9]) * iwa_pkg::BIT_SCALE
                     + 16'(query[iwa_pkg::QRY_BIT_LSB +: 4]));
         in_sfa   <= (query[iwa_pkg::QRY_WORD_LSB +: 9] >= iwa_pkg::SFA_FIRST) &&
                     (query[iwa_pkg::QRY_WORD_LSB +: 9] <= iwa_pkg::SFA_LAST);
         // restart on the falling edge of the restart bit
         link_restart <= wr_fire && (aw_addr == iwa_pkg::OFF_CTRL) &&
                         ctrl[iwa_pkg::CTRL_RESTART_BIT] &&
                         !ctrl_merged[iwa_pkg::CTRL_RESTART_BIT];
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= iwa_pkg::RST_WORD;
         s_axi_rresp   <= iwa_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= is_mapped(s_axi_araddr) ? iwa_pkg::RESP_OKAY
                                                  : iwa_pkg::RESP_SLVERR;
         unique case (s_axi_araddr)
            iwa_pkg::OFF_CTRL:    s_axi_rdata <= ctrl;
            iwa_pkg::OFF_REQ:     s_axi_rdata <= req;
            iwa_pkg::OFF_RESULT:  s_axi_rdata <= {17'h0, res_valid, res_err,
                                                  res_count, res_word};
            iwa_pkg::OFF_MASK:    s_axi_rdata <= {res_barred, res_flags};
            iwa_pkg::OFF_STATUS:  s_axi_rdata <= {24'h0, spec_count, 3'h0, config_error};
            iwa_pkg::OFF_OCCUPY:  s_axi_rdata <= {12'h0, occupy};
            iwa_pkg::OFF_QUERY:   s_axi_rdata <= query;
            iwa_pkg::OFF_BITADDR: s_axi_rdata <= {15'h0, in_sfa, bit_addr};
            iwa_pkg::OFF_ROWMAP:  s_axi_rdata <= {24'h0, res_rows};
            default:              s_axi_rdata <= iwa_pkg::RST_WORD;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_spec_block: assert property (@(posedge aclk) disable iff (!aresetn)
      committed && (kind == iwa_pkg::K_SPECIAL) && !res_err |->
      (res_word == 100 + 10 * unit) && (res_count == 10))
      else $error("special block word wrong");

   a_slave_block: assert property (@(posedge aclk) disable iff (!aresetn)
      committed && (kind == iwa_pkg::K_SLAVE) && !res_err |->
      (res_word == 50 + 10 * unit + pos) && (unit <= 4))
      else $error("slave rack word wrong");

   a_wide_unit: assert property (@(posedge aclk) disable iff (!aresetn)
      committed && (kind == iwa_pkg::K_SLAVE) && wide && (unit == 4) |-> res_err)
      else $error("wide rack at unit four accepted");

   a_optical_word: assert property (@(posedge aclk) disable iff (!aresetn)
      committed && (kind == iwa_pkg::K_OPTICAL) |->
      (res_word == 200 + unit) && (res_word <= 231))
      else $error("optical word wrong");

   a_link_none: assert property (@(posedge aclk) disable iff (!aresetn)
      committed && (kind == iwa_pkg::K_LINK) |-> (res_count == 0))
      else $error("link module given words");

   a_flag_bits: assert property (@(posedge aclk) disable iff (!aresetn)
      committed && (kind == iwa_pkg::K_FUSE_OUT || kind == iwa_pkg::K_ALARM_OUT) |->
      (res_barred[15:8] == 8'hFF) &&
      (res_flags == ((kind == iwa_pkg::K_FUSE_OUT) ? 16'h0100 : 16'h0F00)))
      else $error("fuse or alarm bits wrong");

   a_intr_bits: assert property (@(posedge aclk) disable iff (!aresetn)
      committed && (kind == iwa_pkg::K_INTR_IN) && !res_err |->
      (res_barred == ((rack == 0) ? 16'h00FF : 16'hFFFF)))
      else $error("interrupt input bits wrong");

   a_dense_words: assert property (@(posedge aclk) disable iff (!aresetn)
      committed && (kind == iwa_pkg::K_HD64) && !res_err |->
      (res_word == 30 + 2 * unit) && (res_count == 4) && (unit != 9))
      else $error("64-point words wrong");

   a_restart_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
      link_restart |-> !ctrl[iwa_pkg::CTRL_RESTART_BIT] ##1 !link_restart)
      else $error("restart pulse wrong");

   a_err_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      committed && res_err |-> config_error)
      else $error("error not flagged");

endmodule : iwa_decoder

`default_nettype wire

// [shared/iwa_pkg.sv]
// constants shared by the internal word allocation decoder
`default_nettype none

package iwa_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_REQ     = 8'h04;
   localparam logic [7:0] OFF_RESULT  = 8'h08;
   localparam logic [7:0] OFF_MASK    = 8'h0C;
   localparam logic [7:0] OFF_STATUS  = 8'h10;
   localparam logic [7:0] OFF_OCCUPY  = 8'h14;
   localparam logic [7:0] OFF_QUERY   = 8'h18;
   localparam logic [7:0] OFF_BITADDR = 8'h1C;
   localparam logic [7:0] OFF_ROWMAP  = 8'h20;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTRL_RESTART_BIT = 0;
   localparam int CTRL_CLEAR_BIT   = 1;
   localparam int REQ_KIND_LSB     = 0;   // 4 bits
   localparam int REQ_UNIT_LSB     = 4;   // 5 bits
   localparam int REQ_RACK_LSB     = 9;   // 2 bits
   localparam int REQ_POS_LSB      = 11;  // 5 bits
   localparam int REQ_WIDE_BIT     = 16;
   localparam int QRY_WORD_LSB     = 0;   // 9 bits
   localparam int QRY_BIT_LSB      = 16;  // 4 bits

   // ------------------------------------------------------------
   // module kind codes written into the request register
   // ------------------------------------------------------------
   localparam logic [3:0] K_ORDINARY  = 4'h0;
   localparam logic [3:0] K_SPECIAL   = 4'h1;
   localparam logic [3:0] K_SLAVE     = 4'h2;
   localparam logic [3:0] K_OPTICAL   = 4'h3;
   localparam logic [3:0] K_LINK      = 4'h4;
   localparam logic [3:0] K_FUSE_OUT  = 4'h5;
   localparam logic [3:0] K_ALARM_OUT = 4'h6;
   localparam logic [3:0] K_INTR_IN   = 4'h7;
   localparam logic [3:0] K_HD32      = 4'h8;
   localparam logic [3:0] K_HD64      = 4'h9;
   localparam logic [3:0] K_SERIAL    = 4'hA;

   // ------------------------------------------------------------
   // word map of the internal word area
   // ------------------------------------------------------------
   localparam logic [8:0] RACK_STEP   = 9'h00A;  // 10 words per rack
   localparam logic [4:0] SLOT_LAST   = 5'h09;
   localparam logic [8:0] SPEC_BASE   = 9'h064;  // 100
   localparam logic [8:0] SPEC_STEP   = 9'h00A;  // 10
   localparam logic [4:0] SPEC_UNIT_LAST = 5'h09;
   localparam logic [3:0] SPEC_WORDS  = 4'hA;
   localparam logic [8:0] SLAVE_BASE  = 9'h032;  // 050
   localparam logic [4:0] WIDE_POS_LAST = 5'h13; // 20 words
   localparam logic [8:0] OPT_BASE    = 9'h0C8;  // 200
   localparam logic [8:0] OPT_LAST    = 9'h0E7;  // 231
   localparam logic [8:0] HD_BASE     = 9'h01E;  // 030
   localparam logic [4:0] HD_UNIT_LAST = 5'h09;
   localparam logic [4:0] HD64_UNIT_LAST = 5'h08;
   localparam logic [8:0] SFA_FIRST   = 9'h0EC;  // 236
   localparam logic [8:0] SFA_LAST    = 9'h1FF;  // 511
   localparam logic [15:0] BIT_SCALE  = 16'h0064; // word then two digits
   localparam logic [3:0] BIT_LAST    = 4'hF;

   // ------------------------------------------------------------
   // bit masks and connector row maps
   // ------------------------------------------------------------
   localparam logic [15:0] M_ALL       = 16'hFFFF;
   localparam logic [15:0] M_LOW8      = 16'h00FF;
   localparam logic [15:0] M_HIGH8     = 16'hFF00;
   localparam logic [15:0] M_FUSE      = 16'h0100;
   localparam logic [15:0] M_ALARM     = 16'h0F00;
   localparam logic [7:0]  ROWS_TWO    = 8'h04;   // first A, first B
   localparam logic [7:0]  ROWS_FOUR   = 8'hE4;   // then second A, B

   // ------------------------------------------------------------
   // reset values and bus answers
   // ------------------------------------------------------------
   localparam logic [31:0] RST_WORD    = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : iwa_pkg

`default_nettype wire

// [dv/iwa_cfg_model.sv]
// configuring-party model that builds allocation requests, moving a wide slave rack off unit 4 and dense modules to rack 0
`default_nettype none
module iwa_cfg_model (
   input  wire logic [3:0]  kind,
   input  wire logic [4:0]  unit,
   input  wire logic [1:0]  rack,
   input  wire logic [4:0]  pos,
   input  wire logic        wide,
   output logic      [31:0] req
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] u_ok;
   logic [1:0] r_ok;
   // clamp settings an installer may not choose
   always_comb begin
      u_ok = unit;
      r_ok = rack;
      if (kind == iwa_pkg::K_SLAVE && wide && unit == 5'h04) begin
         u_ok = 5'h03;
      end
      if (kind >= iwa_pkg::K_HD32) begin
         r_ok = 2'h0;
      end
      req = {15'h0000, wide, pos, r_ok, u_ok, kind};
   end
endmodule : iwa_cfg_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the internal word allocation decoder
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rq, v;
   logic awr, wr_r, bv, arr, rv, lrs, cerr;
   logic [1:0] bresp, rresp, rk = 2'h0;
   logic [31:0] rdata;
   logic [3:0] k = 4'h0;
   logic [4:0] u = 5'h00, p = 5'h00;
   logic wd = 0;
   int errors = 0, checked = 0, pulses = 0, n, r;
   iwa_decoder uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rready), .link_restart(lrs), .config_error(cerr));
   iwa_cfg_model cfg (.kind(k), .unit(u), .rack(rk), .pos(p), .wide(wd), .req(rq));
   initial begin
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk) if (lrs === 1'b1) pulses++;
   task print_verdict;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awr) awv <= 0;
         if (wr_r) wv <= 0;
         if (bv) break;
      end
      bready <= 0;
      if (n == 50) begin errors++; print_verdict; end
      chk("bresp", {30'h0, bresp}, 32'h0);
   endtask : wr
   task rd(input logic [7:0] a, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a; arv <= 1; rready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arr) arv <= 0;
         if (rv) break;
      end
      v = rdata;
      rready <= 0;
      if (n == 50) begin errors++; print_verdict; end
      chk("resp", {30'h0, rresp}, {30'h0, er});
   endtask : rd
   // send one request and read back its result
   task dec(input logic [3:0] kk, input int uu, input int rr, input int pp, input logic w);
      k = kk; u = uu[4:0]; rk = rr[1:0]; p = pp[4:0]; wd = w;
      #1;
      wr(iwa_pkg::OFF_REQ, rq);
      repeat (2) @(posedge aclk);
      rd(iwa_pkg::OFF_RESULT, 2'h0);
   endtask : dec
   function automatic logic [31:0] res(input int w, input int c);
      return {17'h0, 1'b1, 1'b0, c[3:0], w[8:0]};
   endfunction : res
   logic [3:0] mk[4] = '{iwa_pkg::K_FUSE_OUT, iwa_pkg::K_ALARM_OUT, 4'h7, 4'h7};
   logic [31:0] mx[4] = '{32'hFFFF0100, 32'hFFFF0F00, 32'h00FF0000, 32'hFFFF0000};
   logic [31:0] mm[4] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFF0000, 32'hFFFF0000};
   initial begin
      void'($urandom(12312));
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rd(iwa_pkg::OFF_STATUS, 2'h0);
      chk("status", v, 32'h0);
      wr(iwa_pkg::OFF_CTRL, 32'h1);
      chk("restart early", pulses, 0);
      wr(iwa_pkg::OFF_CTRL, 32'h0);
      repeat (2) @(posedge aclk);
      chk("restart", pulses, 1);
      dec(iwa_pkg::K_ORDINARY, 0, 1, 3, 0);
      chk("ordinary", v, res(13, 1));
      for (int i = 0; i < 4; i++) begin
         wr(iwa_pkg::OFF_CTRL, 32'h2);
         r = $urandom % 10;
         dec(iwa_pkg::K_SPECIAL, r, 0, 0, 0);
         chk("special", v, res(100 + 10 * r, 10));
         r = $urandom % 5;
         dec(iwa_pkg::K_SLAVE, r, 0, 7, 0);
         chk("slave", v, res(57 + 10 * r, 1));
         r = $urandom % 32;
         dec(iwa_pkg::K_OPTICAL, r, 0, 0, 0);
         chk("optical", v, res(200 + r, 1));
      end
      dec(iwa_pkg::K_SLAVE, 3, 0, 15, 1);
      chk("wide", v, res(95, 1));
      dec(iwa_pkg::K_LINK, 0, 0, 2, 0);
      chk("link", v & 32'h7E00, 32'h4000);
      wr(iwa_pkg::OFF_CTRL, 32'h2);
      dec(iwa_pkg::K_SPECIAL, 2, 0, 0, 0);
      dec(iwa_pkg::K_HD64, 0, 0, 0, 0);
      chk("hd64", v, res(30, 4));
      rd(iwa_pkg::OFF_ROWMAP, 2'h0);
      chk("rows", v, 32'hE4);
      dec(iwa_pkg::K_HD32, 9, 0, 0, 0);
      chk("hd32", v, res(48, 2));
      rd(iwa_pkg::OFF_STATUS, 2'h0);
      chk("count", v & 32'hF1, 32'h10);
      dec(iwa_pkg::K_SERIAL, 1, 0, 0, 0);
      chk("overlap", v & 32'h6000, 32'h6000);
      chk("cfg err", cerr, 1'b1);
      dec(iwa_pkg::K_HD64, 9, 0, 0, 0);
      chk("hd64 nine", v & 32'h6000, 32'h6000);
      for (int i = 0; i < 4; i++) begin
         dec(mk[i], 0, i / 3, 1, 0);
         rd(iwa_pkg::OFF_MASK, 2'h0);
         chk("mask", v & mm[i], mx[i]);
      end
      wr(iwa_pkg::OFF_QUERY, {12'h0, 4'hF, 7'h0, 9'd511});
      repeat (2) @(posedge aclk);
      rd(iwa_pkg::OFF_BITADDR, 2'h0);
      chk("bit addr", v & 32'h1FFFF, 32'h10000 + 51115);
      rd(8'h40, iwa_pkg::RESP_SLVERR);
      print_verdict;
   end
endmodule : testbench
`default_nettype wire
